/* hdl/led_param_bank.sv */
// Parameter register bank with nonvolatile save and restore and status readback.
`timescale 1ns/1ps
module led_param_bank
  import lighting_param_pkg::*;
#(
  parameter int NCH = CHANNELS,
  parameter int NUSER = USER_WORDS
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_FUNC,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic REG_DONE,
  output logic REG_ERR,
  output logic [15:0] REG_RDATA,
  output logic NVM_REQ,
  output logic NVM_WE,
  output logic [15:0] NVM_ADDR,
  output logic [15:0] NVM_WDATA,
  input wire logic NVM_ACK,
  input wire logic [15:0] NVM_RDATA,
  input wire logic TRIG_EVENT,
  input wire logic ERROR_EVENT,
  input wire logic SEQ_ADVANCE,
  input wire logic ALARM_SET,
  input wire logic [31:0] ALARM_CODE,
  input wire logic [31:0] MIN_PERIOD,
  input wire logic [31:0] CURRENT_SINGLE,
  input wire logic [31:0] POS_RAIL,
  input wire logic [31:0] BOARD_TEMP,
  input wire logic [31:0] NEG_RAIL,
  input wire logic [NCH*CHAN_VALUES*32-1:0] CHAN_MON,
  input wire logic [$clog2(NUSER)-1:0] PARAM_INDEX,
  output logic [15:0] PARAM_DATA,
  output logic REBOOT,
  output logic SOFT_PULSE,
  output logic ALARM_CLEAR,
  output logic WRITE_ENABLE
);
  localparam int UW = $clog2(NUSER);
  localparam int NW = $clog2(SYS_WORDS + NUSER + 1);
  localparam logic [NW-1:0] SYS_N = NW'(SYS_WORDS);
  localparam logic [NW-1:0] LAST_N = NW'(SYS_WORDS + NUSER - 1);
  localparam logic [15:0] USER_END = ADDR_USER_BASE + 16'(NUSER);
  localparam logic [15:0] SYS_END = ADDR_SYS_BASE + 16'(2 * SYS_WORDS);
  localparam logic [15:0] CHAN_END = ADDR_CHAN_MON + 16'(2 * NCH * CHAN_VALUES);
  localparam logic [UW-1:0] SEQ_START_IX = UW'(ADDR_SEQ_START - ADDR_USER_BASE);
  localparam logic [UW-1:0] SEQ_NUMBER_IX = UW'(ADDR_SEQ_NUMBER - ADDR_USER_BASE);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction : in_range

  nvm_state_type state_q;
  logic [NW-1:0] idx_q;
  logic req_q;
  logic [15:0] nvm_addr_q;
  logic [15:0] nvm_wdata_q;
  logic [15:0] user_q [NUSER];
  logic [15:0] sys_q [SYS_WORDS];
  logic [31:0] trig_q;
  logic [31:0] err_q;
  logic [31:0] alarm_q;
  logic [31:0] seq_q;
  logic wperm_q;
  logic done_q;
  logic derr_q;
  logic [15:0] rdata_q;
  logic [31:0] snap_q;
  logic [15:0] snap_addr_q;
  logic snap_ok_q;
  logic reboot_q;
  logic soft_q;
  logic alarm_clr_q;
  logic [15:0] param_q;

  logic req;
  logic func_rd;
  logic func_wr;
  logic wr_ok;
  logic cmd_go;
  logic [15:0] base;
  logic is_user;
  logic is_sys;
  logic is_op;
  logic is_stat;
  logic is_chan;
  logic rd_hit;
  logic [31:0] live32;
  logic [15:0] rd_val;
  logic [UW-1:0] user_ix;
  logic [NW-1:0] sys_ix;
  logic [15:0] chan_off;
  logic nvm_take;
  logic go_store;
  logic go_restore;
  logic go_trig_clr;
  logic go_err_clr;
  logic go_seq_clr;
  logic [31:0] seq_start;
  logic [31:0] seq_last;

  assign req = REG_RD ^ REG_WR;
  assign func_rd = REG_RD && (REG_FUNC == FUNC_READ);
  assign func_wr = REG_WR && ((REG_FUNC == FUNC_WRITE_ONE) || (REG_FUNC == FUNC_WRITE_MULTI));
  assign base = {REG_ADDR[15:1], 1'b0};
  assign is_user = in_range(REG_ADDR, ADDR_USER_BASE, USER_END);
  assign is_sys = in_range(REG_ADDR, ADDR_SYS_BASE, SYS_END) && !REG_ADDR[0];
  assign is_op = REG_ADDR <= ADDR_SEQ_CLR;
  assign is_chan = in_range(base, ADDR_CHAN_MON, CHAN_END);
  assign user_ix = UW'(REG_ADDR - ADDR_USER_BASE);
  assign sys_ix = NW'((REG_ADDR - ADDR_SYS_BASE) >> 1);
  assign chan_off = base - ADDR_CHAN_MON;
  assign wr_ok = req && func_wr && (is_op || (is_user && state_q == ST_IDLE));
  assign cmd_go = wr_ok && is_op && (REG_WDATA == CMD_ACTIVE);
  assign go_store = cmd_go && (REG_ADDR == ADDR_STORE);
  assign go_restore = cmd_go && (REG_ADDR == ADDR_RESTORE);
  assign go_trig_clr = cmd_go && (REG_ADDR == ADDR_TRIG_CLR);
  assign go_err_clr = cmd_go && (REG_ADDR == ADDR_ERR_CLR);
  assign go_seq_clr = cmd_go && (REG_ADDR == ADDR_SEQ_CLR);
  assign nvm_take = req_q && NVM_ACK;
  assign seq_start = {16'h0000, user_q[SEQ_START_IX]};
  assign seq_last = seq_start + ((user_q[SEQ_NUMBER_IX] == WORD_RESET) ? 32'h00000000 :
                    {16'h0000, user_q[SEQ_NUMBER_IX] - 16'h0001});

  // Live 32-bit value for the word pair at the even base address.
  always_comb begin
    live32 = TOTAL_RESET;
    is_stat = 1'b1;
    case (base)
      ADDR_TRIG_TOTAL: live32 = trig_q;
      ADDR_ERR_TOTAL: live32 = err_q;
      ADDR_ALARM_REASON: live32 = alarm_q;
      ADDR_SEQ_POS: live32 = seq_q;
      ADDR_MIN_PERIOD: live32 = MIN_PERIOD;
      ADDR_CURRENT_SINGLE: live32 = CURRENT_SINGLE;
      ADDR_POS_RAIL: live32 = POS_RAIL;
      ADDR_BOARD_TEMP: live32 = BOARD_TEMP;
      ADDR_NEG_RAIL: live32 = NEG_RAIL;
      default: begin
        is_stat = is_chan;
        if (is_chan) begin
          live32 = CHAN_MON[chan_off[15:1]*32 +: 32];
        end
      end
    endcase
  end

  // Sixteen-bit read value; high half at the even address, low half at the odd one.
  always_comb begin
    rd_val = WORD_RESET;
    rd_hit = 1'b1;
    if (is_stat) begin
      if (!REG_ADDR[0]) begin
        rd_val = live32[31:16];
      end else if (snap_ok_q && snap_addr_q == base) begin
        rd_val = snap_q[15:0];
      end else begin
        rd_val = live32[15:0];
      end
    end else if (is_user) begin
      rd_val = user_q[user_ix];
    end else if (is_sys) begin
      rd_val = sys_q[sys_ix[$clog2(SYS_WORDS)-1:0]];
    end else if (is_op) begin
      case (REG_ADDR)
        ADDR_STORE: rd_val = {15'h0000, state_q == ST_SAVE};
        ADDR_RESTORE: rd_val = {15'h0000, state_q == ST_LOAD};
        ADDR_WPERM: rd_val = {15'h0000, wperm_q};
        default: rd_val = WORD_RESET;
      endcase
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Register port answer, one cycle after the request.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      done_q <= 1'b0;
      derr_q <= 1'b0;
      rdata_q <= WORD_RESET;
    end else begin
      done_q <= REG_RD || REG_WR;
      derr_q <= (REG_RD || REG_WR) && !((req && func_rd && rd_hit) || wr_ok);
      rdata_q <= (req && func_rd && rd_hit) ? rd_val : WORD_RESET;
    end
  end

  // Snapshot of a pair taken when its high half is read.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      snap_q <= TOTAL_RESET;
      snap_addr_q <= WORD_RESET;
      snap_ok_q <= 1'b0;
    end else if (req && func_rd && is_stat) begin
      snap_q <= live32;
      snap_addr_q <= base;
      snap_ok_q <= !REG_ADDR[0];
    end
  end

  // Command strobes, each one cycle wide.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      reboot_q <= 1'b0;
      soft_q <= 1'b0;
      alarm_clr_q <= 1'b0;
    end else begin
      reboot_q <= cmd_go && (REG_ADDR == ADDR_REBOOT);
      soft_q <= cmd_go && (REG_ADDR == ADDR_SOFT_PULSE);
      alarm_clr_q <= cmd_go && (REG_ADDR == ADDR_ALARM_CLR);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wperm_q <= 1'b0;
    end else if (wr_ok && REG_ADDR == ADDR_WPERM) begin
      wperm_q <= REG_WDATA[0];
    end
  end

  // Counters; an event in the cycle of a clear is still counted.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      trig_q <= TOTAL_RESET;
      err_q <= TOTAL_RESET;
    end else begin
      trig_q <= (go_trig_clr ? TOTAL_RESET : trig_q) + {31'h00000000, TRIG_EVENT};
      err_q <= (go_err_clr ? TOTAL_RESET : err_q) + {31'h00000000, ERROR_EVENT};
    end
  end

  // Alarm reason; a new alarm wins over a clear in the same cycle.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      alarm_q <= TOTAL_RESET;
    end else if (ALARM_SET) begin
      alarm_q <= ALARM_CODE;
    end else if (alarm_clr_q) begin
      alarm_q <= TOTAL_RESET;
    end
  end

  // Sequence index wraps from start plus count minus one back to start.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      seq_q <= TOTAL_RESET;
    end else if (go_seq_clr) begin
      seq_q <= seq_start;
    end else if (SEQ_ADVANCE) begin
      seq_q <= (seq_q >= seq_last) ? seq_start : seq_q + 32'h00000001;
    end
  end

  // Storage walk: restore covers system and user words, save only user words.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_q <= ST_LOAD;
      idx_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go_store) begin
            state_q <= ST_SAVE;
            idx_q <= SYS_N;
          end else if (go_restore || reboot_q) begin
            state_q <= ST_LOAD;
            idx_q <= '0;
          end
        end
        ST_SAVE, ST_LOAD: begin
          if (nvm_take) begin
            if (idx_q == LAST_N) begin
              state_q <= ST_IDLE;
            end else begin
              idx_q <= idx_q + NW'(1);
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Storage request held until acknowledged, with address and data loaded on the same edge that raises it.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      req_q <= 1'b0;
      nvm_addr_q <= WORD_RESET;
      nvm_wdata_q <= WORD_RESET;
    end else if (req_q) begin
      req_q <= !NVM_ACK;
    end else begin
      req_q <= state_q != ST_IDLE;
      nvm_addr_q <= 16'(idx_q);
      nvm_wdata_q <= (idx_q >= SYS_N) ? user_q[UW'(idx_q - SYS_N)] : WORD_RESET;
    end
  end

  // Parameter words: host writes when idle, storage fills them during a restore.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      for (int i = 0; i < NUSER; i++) begin
        user_q[i] <= WORD_RESET;
      end
      for (int j = 0; j < SYS_WORDS; j++) begin
        sys_q[j] <= WORD_RESET;
      end
    end else if (nvm_take && state_q == ST_LOAD) begin
      if (idx_q < SYS_N) begin
        sys_q[idx_q[$clog2(SYS_WORDS)-1:0]] <= NVM_RDATA;
      end else begin
        user_q[UW'(idx_q - SYS_N)] <= NVM_RDATA;
      end
    end else if (wr_ok && is_user) begin
      user_q[user_ix] <= REG_WDATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      param_q <= WORD_RESET;
    end else begin
      param_q <= user_q[PARAM_INDEX];
    end
  end

  assign REG_DONE = done_q;
  assign REG_ERR = derr_q;
  assign REG_RDATA = rdata_q;
  assign NVM_REQ = req_q;
  assign NVM_WE = req_q && (state_q == ST_SAVE);
  assign NVM_ADDR = nvm_addr_q;
  assign NVM_WDATA = nvm_wdata_q;
  assign PARAM_DATA = param_q;
  assign REBOOT = reboot_q;
  assign SOFT_PULSE = soft_q;
  assign ALARM_CLEAR = alarm_clr_q;
  assign WRITE_ENABLE = wperm_q;

  sequence soft_write;
    cmd_go && REG_ADDR == ADDR_SOFT_PULSE;
  endsequence
  sequence one_pulse;
    SOFT_PULSE ##1 !SOFT_PULSE;
  endsequence
  sequence store_write;
    go_store && state_q == ST_IDLE;
  endsequence

  a_soft_pulse_once: assert property (@(posedge CLOCK) disable iff (SRST) soft_write |=> one_pulse)
    else $error("soft trigger did not give one pulse");
  a_reboot_strobe: assert property (@(posedge CLOCK) disable iff (SRST)
    (cmd_go && REG_ADDR == ADDR_REBOOT) |=> REBOOT ##1 (!REBOOT && state_q == ST_LOAD))
    else $error("reboot strobe or restore missing");
  a_trig_cleared: assert property (@(posedge CLOCK) disable iff (SRST)
    (go_trig_clr && !TRIG_EVENT) |=> trig_q == TOTAL_RESET)
    else $error("trigger count not cleared");
  a_err_cleared: assert property (@(posedge CLOCK) disable iff (SRST)
    (go_err_clr && ERROR_EVENT) |=> err_q == 32'h00000001)
    else $error("error count clear lost an event");
  a_seq_to_start: assert property (@(posedge CLOCK) disable iff (SRST)
    go_seq_clr |=> seq_q == $past(seq_start))
    else $error("sequence index not set to start");
  a_sys_refused: assert property (@(posedge CLOCK) disable iff (SRST)
    (REG_WR && !REG_RD && is_sys) |=> REG_DONE && REG_ERR)
    else $error("system area write not refused");
  a_status_kept: assert property (@(posedge CLOCK) disable iff (SRST)
    (REG_WR && !REG_RD && base == ADDR_ALARM_REASON && !ALARM_SET && !alarm_clr_q)
    |=> REG_ERR && $stable(alarm_q))
    else $error("read-only status changed by write");
  a_boot_restore: assert property (@(posedge CLOCK) disable iff (SRST)
    $past(SRST) |-> state_q == ST_LOAD && idx_q == '0)
    else $error("no restore after reset");
  a_store_busy: assert property (@(posedge CLOCK) disable iff (SRST)
    store_write |=> state_q == ST_SAVE ##1 (NVM_REQ && NVM_WE && NVM_ADDR == 16'(SYS_N)))
    else $error("save did not start");
  a_nvm_hold: assert property (@(posedge CLOCK) disable iff (SRST)
    (NVM_REQ && !NVM_ACK) |=> NVM_REQ && $stable(NVM_ADDR) && $stable(NVM_WDATA))
    else $error("storage request dropped early");
  a_pair_match: assert property (@(posedge CLOCK) disable iff (SRST)
    (req && func_rd && is_stat && !REG_ADDR[0]) ##1 (req && func_rd && REG_ADDR == snap_addr_q + 16'h0001)
    |=> REG_RDATA == $past(snap_q[15:0]))
    else $error("pair halves inconsistent");
endmodule : led_param_bank

/* hdl/lighting_param_pkg.sv */
// Register map, command codes and state encodings of the lighting parameter bank.
package lighting_param_pkg;
  localparam logic [15:0] ADDR_REBOOT = 16'h0000;
  localparam logic [15:0] ADDR_STORE = 16'h0001;
  localparam logic [15:0] ADDR_RESTORE = 16'h0002;
  localparam logic [15:0] ADDR_WPERM = 16'h0003;
  localparam logic [15:0] ADDR_ALARM_CLR = 16'h0004;
  localparam logic [15:0] ADDR_SOFT_PULSE = 16'h0005;
  localparam logic [15:0] ADDR_TRIG_CLR = 16'h0006;
  localparam logic [15:0] ADDR_ERR_CLR = 16'h0007;
  localparam logic [15:0] ADDR_SEQ_CLR = 16'h0008;
  localparam logic [15:0] ADDR_TRIG_TOTAL = 16'h0100;
  localparam logic [15:0] ADDR_ERR_TOTAL = 16'h0102;
  localparam logic [15:0] ADDR_ALARM_REASON = 16'h0104;
  localparam logic [15:0] ADDR_SEQ_POS = 16'h0106;
  localparam logic [15:0] ADDR_MIN_PERIOD = 16'h0108;
  localparam logic [15:0] ADDR_CURRENT_SINGLE = 16'h010A;
  localparam logic [15:0] ADDR_POS_RAIL = 16'h010C;
  localparam logic [15:0] ADDR_BOARD_TEMP = 16'h010E;
  localparam logic [15:0] ADDR_NEG_RAIL = 16'h0110;
  localparam logic [15:0] ADDR_CHAN_MON = 16'h0124;
  localparam logic [15:0] ADDR_SYS_BASE = 16'h0200;
  localparam logic [15:0] ADDR_USER_BASE = 16'h0300;
  localparam logic [15:0] ADDR_SEQ_START = 16'h0306;
  localparam logic [15:0] ADDR_SEQ_NUMBER = 16'h0307;
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] FUNC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
  localparam logic [15:0] CMD_ACTIVE = 16'h0001;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [31:0] TOTAL_RESET = 32'h00000000;
  localparam int SYS_WORDS = 6;
  localparam int USER_WORDS = 72;
  localparam int CHAN_VALUES = 3;
  localparam int CHANNELS = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_LOAD = 3'b100
  } nvm_state_type;
endpackage : lighting_param_pkg

/* sim/nvm_store.sv */
// Behavioural nonvolatile word store answering the bank's storage handshake.
`timescale 1ns/1ps
module nvm_store #(
  parameter int WORDS = 78
) (
  input wire logic CLOCK,
  input wire logic NVM_REQ,
  input wire logic NVM_WE,
  input wire logic [15:0] NVM_ADDR,
  input wire logic [15:0] NVM_WDATA,
  input wire logic [1:0] DELAY,
  output logic NVM_ACK,
  output logic [15:0] NVM_RDATA
);
  logic [15:0] mem [WORDS];
  int wait_q;
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem[i] = 16'hA500 + 16'(i);
    end
    NVM_ACK = 1'b0;
    NVM_RDATA = 16'h0000;
    wait_q = 0;
  end
  // Contents are never cleared, so they outlive any reset of the bank.
  always @(posedge CLOCK) begin
    if (NVM_REQ && NVM_ACK) begin
      if (NVM_WE) begin
        mem[NVM_ADDR] <= NVM_WDATA;
      end
      NVM_ACK <= 1'b0;
      NVM_RDATA <= ~NVM_RDATA;
      wait_q <= 0;
    end else if (!NVM_REQ) begin
      NVM_ACK <= 1'b0;
      wait_q <= 0;
    end else if (wait_q >= int'(DELAY)) begin
      NVM_ACK <= 1'b1;
      NVM_RDATA <= mem[NVM_ADDR];
    end else begin
      wait_q <= wait_q + 1;
    end
  end
endmodule : nvm_store

/* sim/testbench.sv */
// Self-checking bench for the lighting parameter bank and its storage.
`timescale 1ns/1ps
`define CHECK(nm, ex, ac) begin samples_checked++; if ((ac) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, ac); end end
module testbench
  import lighting_param_pkg::*;
;
  logic CLOCK, SRST, REG_RD, REG_WR, REG_DONE, REG_ERR, NVM_REQ, NVM_WE, NVM_ACK;
  logic TRIG_EVENT, ERROR_EVENT, SEQ_ADVANCE, ALARM_SET, REBOOT, SOFT_PULSE, ALARM_CLEAR, WRITE_ENABLE;
  logic [7:0] REG_FUNC;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, NVM_ADDR, NVM_WDATA, NVM_RDATA, PARAM_DATA, got;
  logic [31:0] ALARM_CODE, MIN_PERIOD, CURRENT_SINGLE, POS_RAIL, BOARD_TEMP, NEG_RAIL;
  logic [CHANNELS*CHAN_VALUES*32-1:0] CHAN_MON;
  logic [6:0] PARAM_INDEX;
  logic [1:0] DELAY;
  logic err, p_reboot, p_soft, p_alarm;
  logic [15:0] st_addr [5];
  int mismatches, samples_checked;

  led_param_bank DUT (.CLOCK(CLOCK), .SRST(SRST), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_FUNC(REG_FUNC),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_DONE(REG_DONE), .REG_ERR(REG_ERR),
    .REG_RDATA(REG_RDATA), .NVM_REQ(NVM_REQ), .NVM_WE(NVM_WE), .NVM_ADDR(NVM_ADDR),
    .NVM_WDATA(NVM_WDATA), .NVM_ACK(NVM_ACK), .NVM_RDATA(NVM_RDATA), .TRIG_EVENT(TRIG_EVENT),
    .ERROR_EVENT(ERROR_EVENT), .SEQ_ADVANCE(SEQ_ADVANCE), .ALARM_SET(ALARM_SET),
    .ALARM_CODE(ALARM_CODE), .MIN_PERIOD(MIN_PERIOD), .CURRENT_SINGLE(CURRENT_SINGLE),
    .POS_RAIL(POS_RAIL), .BOARD_TEMP(BOARD_TEMP), .NEG_RAIL(NEG_RAIL), .CHAN_MON(CHAN_MON),
    .PARAM_INDEX(PARAM_INDEX), .PARAM_DATA(PARAM_DATA), .REBOOT(REBOOT), .SOFT_PULSE(SOFT_PULSE),
    .ALARM_CLEAR(ALARM_CLEAR), .WRITE_ENABLE(WRITE_ENABLE));
  nvm_store store (.CLOCK(CLOCK), .NVM_REQ(NVM_REQ), .NVM_WE(NVM_WE), .NVM_ADDR(NVM_ADDR),
    .NVM_WDATA(NVM_WDATA), .DELAY(DELAY), .NVM_ACK(NVM_ACK), .NVM_RDATA(NVM_RDATA));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // One register request, held across one taking edge, answer sampled in its cycle.
  task automatic access(input logic wr, input logic [7:0] fn, input logic [15:0] a, input logic [15:0] d);
    @(negedge CLOCK);
    REG_RD = !wr;
    REG_WR = wr;
    REG_FUNC = fn;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLOCK);
    `CHECK("done", 1'b1, REG_DONE)
    got = REG_RDATA;
    err = REG_ERR;
    p_reboot = REBOOT;
    p_soft = SOFT_PULSE;
    p_alarm = ALARM_CLEAR;
    REG_RD = 1'b0;
    REG_WR = 1'b0;
  endtask : access

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    access(1'b1, FUNC_WRITE_ONE, a, d);
    `CHECK("write err", 1'b0, err)
  endtask : wr

  task automatic rchk(input logic [15:0] a, input logic [15:0] ex);
    access(1'b0, FUNC_READ, a, 16'h0000);
    `CHECK("read err", 1'b0, err)
    `CHECK("rdata", ex, got)
  endtask : rchk

  task automatic echk(input logic w, input logic [7:0] fn, input logic [15:0] a, input logic [15:0] d);
    access(w, fn, a, d);
    `CHECK("refused", 1'b1, err)
  endtask : echk

  task automatic wait_idle(input logic [15:0] a);
    int n;
    n = 0;
    do begin
      access(1'b0, FUNC_READ, a, 16'h0000);
      n++;
    end while (got !== 16'h0000 && n < 500);
    if (got !== 16'h0000) begin
      mismatches++;
      finish_test();
    end
  endtask : wait_idle

  task automatic tend(input string nm);
    $display("test %s finished", nm);
  endtask : tend

  initial begin
    repeat (100000) @(posedge CLOCK);
    mismatches++;
    finish_test();
  end

  initial begin
    SRST = 1'b1; REG_RD = 1'b0; REG_WR = 1'b0; REG_FUNC = 8'h00; REG_ADDR = 16'h0000;
    REG_WDATA = 16'h0000; TRIG_EVENT = 1'b0; ERROR_EVENT = 1'b0; SEQ_ADVANCE = 1'b0;
    ALARM_SET = 1'b0; ALARM_CODE = 32'h0012ABCD; PARAM_INDEX = 7'h00; DELAY = 2'h0;
    st_addr = '{ADDR_MIN_PERIOD, ADDR_CURRENT_SINGLE, ADDR_POS_RAIL, ADDR_BOARD_TEMP, ADDR_NEG_RAIL};
    MIN_PERIOD = 32'h41000500; CURRENT_SINGLE = 32'h41010501; POS_RAIL = 32'h41020502;
    BOARD_TEMP = 32'h41030503; NEG_RAIL = 32'h41040504;
    for (int k = 0; k < CHANNELS * CHAN_VALUES; k++) begin
      CHAN_MON[k*32 +: 32] = {16'h1000 + 16'(k), 16'h2000 + 16'(k)};
    end
    repeat (10) @(negedge CLOCK);
    SRST = 1'b0;
    rchk(ADDR_RESTORE, 16'h0001);
    wait_idle(ADDR_RESTORE);
    rchk(ADDR_USER_BASE, 16'hA506);
    rchk(ADDR_USER_BASE + 16'h0047, 16'hA54D);
    rchk(ADDR_SYS_BASE, 16'hA500);
    rchk(ADDR_SYS_BASE + 16'h000A, 16'hA505);
    for (int a = 0; a < 9; a++) begin
      rchk(16'(a), 16'h0000);
    end
    tend("restore");
    for (int i = 0; i < 5; i++) begin
      rchk(st_addr[i], 16'h4100 + 16'(i));
      rchk(st_addr[i] + 16'h0001, 16'h0500 + 16'(i));
    end
    for (int k = 0; k < CHANNELS * CHAN_VALUES; k++) begin
      rchk(ADDR_CHAN_MON + 16'(2 * k), 16'h1000 + 16'(k));
      rchk(ADDR_CHAN_MON + 16'(2 * k + 1), 16'h2000 + 16'(k));
    end
    tend("status");
    echk(1'b1, FUNC_WRITE_ONE, ADDR_SYS_BASE, 16'h0001);
    rchk(ADDR_SYS_BASE, 16'hA500);
    echk(1'b1, FUNC_WRITE_MULTI, ADDR_CHAN_MON, 16'h0001);
    rchk(ADDR_CHAN_MON, 16'h1000);
    echk(1'b0, FUNC_WRITE_ONE, ADDR_TRIG_TOTAL, 16'h0000);
    echk(1'b1, FUNC_READ, ADDR_USER_BASE, 16'h0001);
    echk(1'b0, FUNC_READ, ADDR_SYS_BASE + 16'h0001, 16'h0000);
    access(1'b1, FUNC_WRITE_MULTI, ADDR_WPERM, 16'h0001);
    `CHECK("wperm", 1'b1, WRITE_ENABLE)
    rchk(ADDR_WPERM, 16'h0001);
    wr(ADDR_WPERM, 16'h0000);
    tend("access");
    repeat (5) begin
      @(negedge CLOCK);
      TRIG_EVENT = 1'b1;
    end
    @(negedge CLOCK);
    TRIG_EVENT = 1'b0;
    rchk(ADDR_TRIG_TOTAL, 16'h0000);
    repeat (2) begin
      @(negedge CLOCK);
      TRIG_EVENT = 1'b1;
    end
    @(negedge CLOCK);
    TRIG_EVENT = 1'b0;
    rchk(ADDR_TRIG_TOTAL + 16'h0001, 16'h0005);
    wr(ADDR_TRIG_CLR, 16'h0001);
    rchk(ADDR_TRIG_TOTAL + 16'h0001, 16'h0000);
    wr(ADDR_SOFT_PULSE, 16'h0001);
    `CHECK("soft pulse", 1'b1, p_soft)
    @(negedge CLOCK);
    `CHECK("soft pulse end", 1'b0, SOFT_PULSE)
    wr(ADDR_SOFT_PULSE, 16'h0002);
    `CHECK("soft pulse none", 1'b0, p_soft)
    repeat (3) begin
      @(negedge CLOCK);
      ERROR_EVENT = 1'b1;
    end
    @(negedge CLOCK);
    ERROR_EVENT = 1'b0;
    rchk(ADDR_ERR_TOTAL + 16'h0001, 16'h0003);
    wr(ADDR_ERR_CLR, 16'h0001);
    rchk(ADDR_ERR_TOTAL + 16'h0001, 16'h0000);
    fork
      wr(ADDR_ERR_CLR, 16'h0001);
      begin
        @(negedge CLOCK);
        ERROR_EVENT = 1'b1;
        @(negedge CLOCK);
        ERROR_EVENT = 1'b0;
      end
    join
    rchk(ADDR_ERR_TOTAL + 16'h0001, 16'h0001);
    tend("counters");
    @(negedge CLOCK);
    ALARM_SET = 1'b1;
    @(negedge CLOCK);
    ALARM_SET = 1'b0;
    rchk(ADDR_ALARM_REASON, 16'h0012);
    rchk(ADDR_ALARM_REASON + 16'h0001, 16'hABCD);
    echk(1'b1, FUNC_WRITE_ONE, ADDR_ALARM_REASON + 16'h0001, 16'h0000);
    rchk(ADDR_ALARM_REASON + 16'h0001, 16'hABCD);
    wr(ADDR_ALARM_CLR, 16'h0001);
    `CHECK("alarm clear", 1'b1, p_alarm)
    rchk(ADDR_ALARM_REASON + 16'h0001, 16'h0000);
    wr(ADDR_SEQ_START, 16'h0003);
    wr(ADDR_SEQ_NUMBER, 16'h0004);
    wr(ADDR_SEQ_CLR, 16'h0001);
    rchk(ADDR_SEQ_POS + 16'h0001, 16'h0003);
    repeat (5) begin
      @(negedge CLOCK);
      SEQ_ADVANCE = 1'b1;
    end
    @(negedge CLOCK);
    SEQ_ADVANCE = 1'b0;
    rchk(ADDR_SEQ_POS, 16'h0000);
    rchk(ADDR_SEQ_POS + 16'h0001, 16'h0004);
    tend("alarm and sequence");
    DELAY = 2'h3;
    wr(ADDR_USER_BASE, 16'h1234);
    wr(ADDR_STORE, 16'h0001);
    rchk(ADDR_STORE, 16'h0001);
    wait_idle(ADDR_STORE);
    `CHECK("stored word", 16'h1234, store.mem[6])
    wr(ADDR_USER_BASE, 16'h5555);
    wr(ADDR_RESTORE, 16'h0001);
    wait_idle(ADDR_RESTORE);
    rchk(ADDR_USER_BASE, 16'h1234);
    wr(ADDR_USER_BASE, 16'h7777);
    wr(ADDR_REBOOT, 16'h0001);
    `CHECK("reboot", 1'b1, p_reboot)
    echk(1'b1, FUNC_WRITE_ONE, ADDR_USER_BASE + 16'h0001, 16'h0001);
    wait_idle(ADDR_RESTORE);
    rchk(ADDR_USER_BASE, 16'h1234);
    rchk(ADDR_REBOOT, 16'h0000);
    `CHECK("param data", 16'h1234, PARAM_DATA)
    tend("storage");
    finish_test();
  end
endmodule : testbench
